// ===== logic/fnip_core.sv
/*
   Flags word and next-instruction offset of the core, with an Avalon-MM
   slave for software access, a result-flag generator and the control
   decisions that the flags steer.
   Assumes the execution unit presents one retire pulse per instruction and
   that the bus master holds its request until waitrequest falls.
*/
`timescale 1ns/1ns
module fnip_core #(
   parameter int W = 32
) (
   input  wire logic           SYS_CLK,
   input  wire logic           RST,
   input  wire logic [3:0]     AVS_ADDRESS,
   input  wire logic           AVS_READ,
   input  wire logic           AVS_WRITE,
   input  wire logic [31:0]    AVS_WRITEDATA,
   input  wire logic [3:0]     AVS_BYTEENABLE,
   output logic [31:0]         AVS_READDATA,
   output logic                AVS_WAITREQUEST,
   input  wire logic           RETIRE,
   input  wire logic [W-1:0]   INSTR_LEN,
   input  wire logic           BRANCH_LOAD,
   input  wire logic [W-1:0]   BRANCH_TARGET,
   input  wire logic           ALU_VALID,
   input  wire fnip_pkg::fnip_op_t ALU_OP,
   input  wire logic [31:0]    ALU_A,
   input  wire logic [31:0]    ALU_B,
   input  wire logic           POP_FLAGS,
   input  wire logic           INTERRUPT_RETURN_POP,
   input  wire logic           TASK_SWITCH,
   input  wire logic [31:0]    POP_VALUE,
   input  wire logic [1:0]     CUR_PRIV,
   input  wire logic           MASKABLE_IRQ_PIN,
   input  wire logic           IO_INSTR,
   input  wire logic           PRIV_OPCODE,
   input  wire logic           MISALIGNED,
   input  wire logic           DEBUG_HIT,
   output logic [31:0]         NEXT_INSTR_OFFSET,
   output logic [31:0]         STATUS_CONTROL_WORD,
   output logic [15:0]         FLAGS16,
   output logic                STEP_TRAP,
   output logic                IRQ_TAKE,
   output logic                STRING_DECREMENT,
   output logic                IO_FAULT,
   output logic                IO_BITMAP_CHECK,
   output logic                PRIV_FAULT,
   output logic                V86_SEGMENTS,
   output logic                ALIGN_FAULT,
   output logic                DEBUG_FAULT
);
   // the offset adder and bus lanes are 32 bits wide; refuse any other width
   if (W != 32) begin : g_bad_width
      $error("fnip_core: offset width must be 32");
   end

   logic [31:0] flags;
   logic [31:0] offset;
   logic [2:0]  config_bits;
   logic        trap_armed;
   logic        bus_ack;
   logic [31:0] alu_flags;
   logic [31:0] next_flags;

   // even parity of the low result byte
   function automatic logic even_ones(input logic [7:0] v);
      even_ones = ~^v;
   endfunction

   // byte-lane merge for software writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      lane_merge = (wd & m) | (old & ~m);
   endfunction

   wire prot_mode = config_bits[fnip_pkg::CFG_PE_POS];
   wire io_ok     = CUR_PRIV <= flags[fnip_pkg::IO_PRIVILEGE_LEVEL_HI:fnip_pkg::IO_PRIVILEGE_LEVEL_LO];
   wire bus_wr    = AVS_WRITE & ~bus_ack;
   wire wr_flags  = bus_wr & (AVS_ADDRESS == fnip_pkg::ADDR_FLAGS);
   wire wr_flag16 = bus_wr & (AVS_ADDRESS == fnip_pkg::ADDR_FLAGS16);

   // result flags from the alu operands
   always_comb begin
      logic [32:0] sum;
      logic [4:0]  low;
      logic [31:0] res;
      logic        c_in_sign;
      sum = 33'h0;
      low = 5'h0;
      res = 32'h0;
      c_in_sign = 1'b0;
      alu_flags = flags;
      if (ALU_OP == fnip_pkg::FNIP_OP_SUB) begin
         sum = {1'b0, ALU_A} - {1'b0, ALU_B};
         low = {1'b0, ALU_A[3:0]} - {1'b0, ALU_B[3:0]};
         c_in_sign = ALU_A[31] ^ ALU_B[31] ^ sum[31];
      end else if (ALU_OP == fnip_pkg::FNIP_OP_ADD) begin
         sum = {1'b0, ALU_A} + {1'b0, ALU_B};
         low = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]};
         c_in_sign = ALU_A[31] ^ ALU_B[31] ^ sum[31];
      end else begin
         sum = {1'b0, ALU_A & ALU_B};
      end
      res = sum[31:0];
      alu_flags[fnip_pkg::CARRY_POS]  = sum[32];
      alu_flags[fnip_pkg::PARITY_POS] = even_ones(res[7:0]);
      alu_flags[fnip_pkg::AUX_POS]    = low[4];
      alu_flags[fnip_pkg::ZERO_POS]   = (res == 32'h0);
      alu_flags[fnip_pkg::SIGN_POS]   = res[31];
      alu_flags[fnip_pkg::OVF_POS]    = c_in_sign ^ sum[32];
   end

   // next flags word, priority: pop or task switch, software, alu; a step clears the trap bit over all of them
   always_comb begin
      logic [31:0] cand;
      cand = flags;
      next_flags = flags;
      if (POP_FLAGS | TASK_SWITCH) begin
         cand = POP_VALUE;
         if (!io_ok && !TASK_SWITCH) begin
            cand[fnip_pkg::IEN_POS] = flags[fnip_pkg::IEN_POS];
         end
         if (!(TASK_SWITCH || (INTERRUPT_RETURN_POP && CUR_PRIV == 2'h0))) begin
            cand[fnip_pkg::V86_POS] = flags[fnip_pkg::V86_POS];
         end
      end else if (wr_flags) begin
         cand = lane_merge(flags, AVS_WRITEDATA, AVS_BYTEENABLE);
         cand[fnip_pkg::V86_POS] = flags[fnip_pkg::V86_POS];
      end else if (wr_flag16) begin
         // upper lanes masked off, so the high half keeps its old value
         cand = lane_merge(flags, AVS_WRITEDATA, {2'h0, AVS_BYTEENABLE[1:0]});
      end else if (ALU_VALID) begin
         cand = alu_flags;
      end
      if (!config_bits[fnip_pkg::CFG_QUERY_POS]) begin
         cand[fnip_pkg::QUERY_POS] = flags[fnip_pkg::QUERY_POS];
      end
      if (STEP_TRAP) begin
         cand[fnip_pkg::TRAP_POS] = 1'b0;
      end
      if (RETIRE && !(POP_FLAGS | TASK_SWITCH | wr_flags)) begin
         cand[fnip_pkg::RESUME_POS] = 1'b0;
      end
      next_flags = (cand & fnip_pkg::FLAGS_WMASK) | fnip_pkg::FLAGS_FIXED;
   end

   // flags word register
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         flags <= fnip_pkg::FLAGS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   // trap arms when an instruction retires with the trap bit set
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         trap_armed <= 1'b0;
      end else if (STEP_TRAP) begin
         trap_armed <= 1'b0;
      end else if (RETIRE && flags[fnip_pkg::TRAP_POS]) begin
         trap_armed <= 1'b1;
      end
   end

   // next instruction offset; a load beats sequential advance
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         offset <= fnip_pkg::OFFSET_RESET;
      end else if (BRANCH_LOAD) begin
         offset <= BRANCH_TARGET;
      end else if (bus_wr && AVS_ADDRESS == fnip_pkg::ADDR_OFFSET) begin
         offset <= lane_merge(offset, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (RETIRE) begin
         offset <= offset + INSTR_LEN;
      end
   end

   // configuration bits standing in for the outside control registers
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         config_bits <= fnip_pkg::CONFIG_RESET;
      end else if (bus_wr && AVS_ADDRESS == fnip_pkg::ADDR_CONFIG && AVS_BYTEENABLE[0]) begin
         config_bits <= AVS_WRITEDATA[2:0];
      end
   end

   // one wait cycle per access: ack rises the cycle after a request
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= (AVS_READ | AVS_WRITE) & ~bus_ack;
      end
   end

   // read data registered alongside the ack; unmapped reads give zero
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         AVS_READDATA <= 32'h0;
      end else if (AVS_READ && !bus_ack) begin
         case (AVS_ADDRESS)
            fnip_pkg::ADDR_FLAGS:   AVS_READDATA <= flags;
            fnip_pkg::ADDR_FLAGS16: AVS_READDATA <= {16'h0, flags[15:0]};
            fnip_pkg::ADDR_OFFSET:  AVS_READDATA <= offset;
            fnip_pkg::ADDR_CONFIG:  AVS_READDATA <= {29'h0, config_bits};
            default:                AVS_READDATA <= 32'h0;
         endcase
      end
   end

   assign AVS_WAITREQUEST     = (AVS_READ | AVS_WRITE) & ~bus_ack;
   assign NEXT_INSTR_OFFSET   = offset;
   assign STATUS_CONTROL_WORD = flags;
   assign FLAGS16             = flags[15:0];
   assign STEP_TRAP           = trap_armed;
   // decisions the flags steer; pins are taken as synchronous
   assign IRQ_TAKE         = MASKABLE_IRQ_PIN & flags[fnip_pkg::IEN_POS];
   assign STRING_DECREMENT = flags[fnip_pkg::DIR_POS];
   // above the io level: virtual mode consults the permission bitmap, else fault
   assign IO_FAULT         = IO_INSTR & prot_mode & ~io_ok
                             & ~flags[fnip_pkg::V86_POS];
   assign IO_BITMAP_CHECK  = IO_INSTR & prot_mode & ~io_ok
                             & flags[fnip_pkg::V86_POS];
   assign V86_SEGMENTS     = prot_mode & flags[fnip_pkg::V86_POS];
   assign PRIV_FAULT       = PRIV_OPCODE & V86_SEGMENTS;
   assign ALIGN_FAULT      = MISALIGNED & flags[fnip_pkg::ALIGN_POS]
                             & config_bits[fnip_pkg::CFG_AM_POS];
   assign DEBUG_FAULT      = DEBUG_HIT & ~flags[fnip_pkg::RESUME_POS];
   // nested-task bit is held in the word for task logic outside; stored at bit 14

   a_fixed_bits: assert property (@(posedge SYS_CLK) disable iff (RST)
      (flags & ~fnip_pkg::FLAGS_WMASK) == fnip_pkg::FLAGS_FIXED)
      else $error("fixed flag bits changed");
   a_branch_load: assert property (@(posedge SYS_CLK) disable iff (RST)
      BRANCH_LOAD |=> offset == $past(BRANCH_TARGET))
      else $error("branch target not loaded");
   a_seq_advance: assert property (@(posedge SYS_CLK) disable iff (RST)
      RETIRE && !BRANCH_LOAD && !bus_wr |=> offset == $past(offset) + $past(INSTR_LEN))
      else $error("offset did not advance");
   a_zero_flag: assert property (@(posedge SYS_CLK) disable iff (RST)
      ALU_VALID && !POP_FLAGS && !TASK_SWITCH && !bus_wr && ALU_OP == fnip_pkg::FNIP_OP_SUB
      && ALU_A == ALU_B |=> flags[fnip_pkg::ZERO_POS] && !flags[fnip_pkg::CARRY_POS])
      else $error("zero or carry wrong on equal subtract");
   a_step_trap: assert property (@(posedge SYS_CLK) disable iff (RST)
      STEP_TRAP |=> !flags[fnip_pkg::TRAP_POS] && !STEP_TRAP)
      else $error("trap bit survived single step");
   a_trap_after: assert property (@(posedge SYS_CLK) disable iff (RST)
      RETIRE && flags[fnip_pkg::TRAP_POS] && !STEP_TRAP |=> STEP_TRAP)
      else $error("single step missing");
   a_irq_mask: assert property (@(posedge SYS_CLK) disable iff (RST)
      IRQ_TAKE |-> flags[fnip_pkg::IEN_POS])
      else $error("interrupt taken while masked");
   a_pop_ien: assert property (@(posedge SYS_CLK) disable iff (RST)
      POP_FLAGS && !TASK_SWITCH && !io_ok |=> $stable(flags[fnip_pkg::IEN_POS]))
      else $error("interrupt enable changed by unprivileged pop");
   a_v86_set: assert property (@(posedge SYS_CLK) disable iff (RST)
      $rose(flags[fnip_pkg::V86_POS]) |-> $past(TASK_SWITCH)
      || ($past(INTERRUPT_RETURN_POP) && $past(CUR_PRIV) == 2'h0))
      else $error("virtual mode set illegally");
   a_query_lock: assert property (@(posedge SYS_CLK) disable iff (RST)
      !config_bits[fnip_pkg::CFG_QUERY_POS] |=> $stable(flags[fnip_pkg::QUERY_POS]))
      else $error("query bit changed while locked");
   a_align_fault: assert property (@(posedge SYS_CLK) disable iff (RST)
      ALIGN_FAULT |-> MISALIGNED && flags[fnip_pkg::ALIGN_POS]
      && config_bits[fnip_pkg::CFG_AM_POS])
      else $error("alignment fault without both enables");
endmodule

// ===== logic/fnip_pkg.sv
/*
   Package for the flags / next-instruction-offset block: register offsets,
   flag bit positions, reset values and the alu operation codes.
   Assumes the core clock and reset of the surrounding processor core.
*/
// Summary of operation
// - next offset advances per instruction unless a branch, interrupt or fault loads it
// - low half of the flags word is readable as a separate 16-bit view
// - bit 0 set on carry or borrow out of result top bit
// - bit 2 set when low result byte holds an even count of ones
// - bit 4 set on carry or borrow at result bit three
// - bit 6 set when the result is zero
// - bit 7 copies the result sign bit
// - bit 11 is carry into sign xor carry out of top bit
// - bit 8 raises single-step after next instruction; that step clears bit 8
// - maskable interrupt serviced only while bit 9 is set
// - string ops increment index registers when bit 10 clear, decrement when set
// - bits 13:12 give highest privilege allowed I/O without fault in protected mode
// - popped flags alter interrupt enable only when privilege not above I/O field
// - bit 14 marks a nested task in protected mode
// - bit 16 set at a boundary suppresses debug fault on next instruction
// - bit 17 in protected mode gives 8086 segment loads, faults privileged opcodes
// - bit 17 set only by interrupt return at level 0 or task switch
// - misaligned access faults only when bit 18 and align mask bit both set
// - bit 21 writable only while config_reg_four query enable is set
package fnip_pkg;
   // register word byte addresses
   localparam logic [3:0] ADDR_FLAGS    = 4'h0;
   localparam logic [3:0] ADDR_FLAGS16  = 4'h4;
   localparam logic [3:0] ADDR_OFFSET   = 4'h8;
   localparam logic [3:0] ADDR_CONFIG   = 4'hc;
   // flag bit positions
   localparam int CARRY_POS = 0;
   localparam int PARITY_POS = 2;
   localparam int AUX_POS = 4;
   localparam int ZERO_POS = 6;
   localparam int SIGN_POS = 7;
   localparam int TRAP_POS = 8;
   localparam int IEN_POS = 9;
   localparam int DIR_POS = 10;
   localparam int OVF_POS = 11;
   localparam int IO_PRIVILEGE_LEVEL_LO = 12;
   localparam int IO_PRIVILEGE_LEVEL_HI = 13;
   localparam int NEST_POS = 14;
   localparam int RESUME_POS = 16;
   localparam int V86_POS = 17;
   localparam int ALIGN_POS = 18;
   localparam int QUERY_POS = 21;
   // config word bits: processor-query enable, align mask, protected mode
   localparam int CFG_QUERY_POS = 0;
   localparam int CFG_AM_POS = 1;
   localparam int CFG_PE_POS = 2;
   // writable flag bits; all others fixed
   localparam logic [31:0] FLAGS_WMASK = 32'h00277fd5;
   // fixed bit values: bit 1 reads one, other undefined bits zero
   localparam logic [31:0] FLAGS_FIXED = 32'h00000002;
   localparam logic [31:0] FLAGS_RESET = 32'h00000002;
   localparam logic [31:0] OFFSET_RESET = 32'h0000fff0;
   localparam logic [2:0]  CONFIG_RESET = 3'h0;
   // alu operation codes
   typedef enum logic [1:0] {FNIP_OP_LOGIC = 2'h0, FNIP_OP_ADD = 2'h1,
                             FNIP_OP_SUB = 2'h2} fnip_op_t;
endpackage

// ===== test/fnip_core_tb_top.sv
/*
   Self-checking bench for fnip_core: a bench model of the flags word, offset
   and config word is compared with the outputs after every operation.
   Assumes the bus answer timing and retire pulse behaviour of fnip_core.
*/
`timescale 1ns/1ns
module fnip_core_tb_top;
   localparam logic [31:0] WM = fnip_pkg::FLAGS_WMASK;
   logic                clk, rst, rd, wr, ret, brl, aluv, popf, interrupt_return, tsw, wq;
   logic                irq, io, pvo, mis, dbg, stp, irqt, sdec, iof, pvf, v86, alf, dbf, iobm;
   logic [3:0]          adr;
   logic [1:0]          current_priv_level;
   logic [31:0]         wd, rdat, len, tgt, a, b, pv, off, scw, mf, mo;
   logic [15:0]         f16;
   logic [2:0]          mc;
   fnip_pkg::fnip_op_t  op;
   integer              seed, cyc, n_fail, tests_run;
   logic [31:0]         ta[5] = '{32'hffffffff, 32'h7fffffff, 32'h0, 32'h80000000, 32'h5};
   logic [31:0]         tb[5] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h5};
   logic                ts[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

   fnip_core dut_u (.SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wq), .RETIRE(ret), .INSTR_LEN(len), .BRANCH_LOAD(brl),
      .BRANCH_TARGET(tgt), .ALU_VALID(aluv), .ALU_OP(op), .ALU_A(a), .ALU_B(b),
      .POP_FLAGS(popf), .INTERRUPT_RETURN_POP(interrupt_return), .TASK_SWITCH(tsw), .POP_VALUE(pv), .CUR_PRIV(current_priv_level),
      .MASKABLE_IRQ_PIN(irq), .IO_INSTR(io), .PRIV_OPCODE(pvo), .MISALIGNED(mis),
      .DEBUG_HIT(dbg), .NEXT_INSTR_OFFSET(off), .STATUS_CONTROL_WORD(scw), .FLAGS16(f16),
      .STEP_TRAP(stp), .IRQ_TAKE(irqt), .STRING_DECREMENT(sdec), .IO_FAULT(iof),
      .IO_BITMAP_CHECK(iobm), .PRIV_FAULT(pvf), .V86_SEGMENTS(v86), .ALIGN_FAULT(alf),
      .DEBUG_FAULT(dbf));

   // 125 MHz core clock
   always #4 clk = ~clk;

   // hang guard: the run needs well under 5000 cycles
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_fail = n_fail + 1;
         final_report;
      end
   end

   task final_report;
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      tests_run = tests_run + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // model of a flags load; locked bits keep their old value
   function automatic logic [31:0] mrg(input logic [31:0] o, d, lk);
      logic [31:0] n;
      n = (d & WM) | fnip_pkg::FLAGS_FIXED;
      lk = lk | (mc[0] ? 32'h0 : 32'h0020_0000);
      return (n & ~lk) | (o & lk);
   endfunction

   function automatic logic [31:0] rexp(input logic [3:0] x);
      case (x)
         4'h0: return mf;
         4'h4: return {16'h0, mf[15:0]};
         4'h8: return mo;
         4'hc: return {29'h0, mc};
         default: return 32'h0;
      endcase
   endfunction

   // one bus access; waitrequest and read data taken at the rising edge that ends it
   task automatic bus(input logic w, input logic [3:0] x, input logic [31:0] d);
      logic        k;
      logic [31:0] rv;
      adr <= x;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         k = wq;
         rv = rdat;
      end while (k !== 1'b0);
      wr <= 1'b0;
      rd <= 1'b0;
      if (!w) chk(rv, rexp(x), "read");
      else if (x == 4'h0) mf = mrg(mf, d, 32'h0002_0000);
      else if (x == 4'h4) mf = mrg(mf, {mf[31:16], d[15:0]}, 32'h0002_0000);
      else if (x == 4'h8) mo = d;
      else if (x == 4'hc) mc = d[2:0];
      @(posedge clk);
   endtask

   // full state compare; level inputs are shuffled first so the decisions vary
   task automatic st;
      {irq, io, pvo, mis, dbg} <= 5'($random(seed));
      @(negedge clk);
      chk(scw, mf, "flags");
      chk(f16, mf[15:0], "flags16");
      chk(off, mo, "offset");
      chk(stp, 0, "step idle");
      chk(irqt, irq & mf[9], "irq");
      chk(sdec, mf[10], "dir");
      chk(iof, mc[2] & io & (current_priv_level > mf[13:12]) & !mf[17], "io");
      chk(iobm, mc[2] & io & (current_priv_level > mf[13:12]) & mf[17], "io bitmap");
      chk(pvf, mc[2] & mf[17] & pvo, "priv");
      chk(v86, mc[2] & mf[17], "v86");
      chk(alf, mis & mf[18] & mc[1], "align");
      chk(dbf, dbg & !mf[16], "debug");
      @(posedge clk);
   endtask

   // one retired instruction, with or without a branch load
   task automatic instr(input logic br);
      logic        t;
      logic [31:0] l, g;
      t = mf[8];
      l = $random(seed) & 32'hf;
      g = $random(seed);
      ret <= 1'b1;
      len <= l;
      brl <= br;
      tgt <= g;
      @(posedge clk);
      ret <= 1'b0;
      brl <= 1'b0;
      mo = br ? g : mo + l;
      mf[16] = 1'b0;
      @(negedge clk);
      chk(stp, t, "step");
      @(posedge clk);
      mf[8] = 1'b0;
   endtask

   // k: 0 logic and, 1 add, 2 subtract
   task automatic alu(input logic [1:0] k, input logic [31:0] x, y);
      logic [32:0] r;
      logic        s;
      s = (k == 2'h2);
      r = s ? {1'b0, x} - {1'b0, y} : (k == 2'h1) ? {1'b0, x} + {1'b0, y} : {1'b0, x & y};
      aluv <= 1'b1;
      op <= fnip_pkg::fnip_op_t'(k);
      a <= x;
      b <= y;
      @(posedge clk);
      aluv <= 1'b0;
      mf[0] = r[32];
      mf[2] = ~^r[7:0];
      mf[4] = (k != 2'h0) && (x[4] ^ y[4] ^ r[4]);
      mf[6] = (r[31:0] == 32'h0);
      mf[7] = r[31];
      mf[11] = (k != 2'h0) && (x[31] == (y[31] ^ s)) && (r[31] != x[31]);
   endtask

   // pop or task switch; the query bit is kept so its lock never matters here
   task automatic pop(input logic sw, input logic ir, input logic [1:0] p);
      logic [31:0] v, lk;
      v = $random(seed);
      v[21] = mf[21];
      lk = (sw || (ir && p == 2'h0)) ? 32'h0 : 32'h0002_0000;
      if (!sw && p > mf[13:12]) lk[9] = 1'b1;
      popf <= !sw;
      tsw <= sw;
      interrupt_return <= ir & !sw;
      pv <= v;
      current_priv_level <= p;
      @(posedge clk);
      {popf, tsw, interrupt_return} <= 3'h0;
      mf = mrg(mf, v, lk);
   endtask

   // directed boundary cases first, then a seeded random mix
   initial begin
      seed = 32'h56cb;
      {cyc, n_fail, tests_run} = '0;
      {clk, rd, wr, ret, brl, aluv, popf, interrupt_return, tsw, irq, io, pvo, mis, dbg} = '0;
      {adr, current_priv_level, wd, len, tgt, a, b, pv} = '0;
      op = fnip_pkg::FNIP_OP_ADD;
      rst = 1'b1;
      mf = fnip_pkg::FLAGS_RESET;
      mo = fnip_pkg::OFFSET_RESET;
      mc = fnip_pkg::CONFIG_RESET;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 16; i++) bus(1'b0, 4'(i), 32'h0);
      bus(1'b1, 4'h0, 32'hffffffff);
      bus(1'b0, 4'h0, 32'h0);
      bus(1'b1, 4'hc, 32'h7);
      bus(1'b1, 4'h0, 32'hffffffff);
      bus(1'b0, 4'h0, 32'h0);
      bus(1'b1, 4'h0, 32'h0000_0100);
      st;
      instr(1'b0);
      st;
      for (int i = 0; i < 5; i++) begin
         alu(ts[i] ? 2'h2 : 2'h1, ta[i], tb[i]);
         st;
      end
      for (int i = 0; i < 300; i++) begin
         case ($unsigned($random(seed)) % 6)
            0: alu(2'($unsigned($random(seed)) % 3), $random(seed), $random(seed));
            1: instr(1'($random(seed)));
            2: bus(1'b1, {2'($random(seed)), 2'b00}, $random(seed));
            3: pop(1'b0, 1'($random(seed)), 2'($random(seed)));
            4: pop(1'b1, 1'b0, 2'($random(seed)));
            default: bus(1'b0, 4'($random(seed)), 32'h0);
         endcase
         st;
      end
      final_report;
   end
endmodule
